// ==== rtl/sample_fifo_pkg.sv ====
package sample_fifo_pkg;
    // register offsets on the byte register port
    localparam logic [6:0] ADDR_INT_CFG = 7'h0B;
    localparam logic [6:0] ADDR_CTRL_TWO = 7'h11;
    localparam logic [6:0] ADDR_IRQ_ROUTE = 7'h12;
    localparam logic [6:0] ADDR_BUF_CTRL = 7'h14;
    localparam logic [6:0] ADDR_BUF_STATE = 7'h26;
    localparam logic [6:0] ADDR_P_LOW = 7'h28;
    localparam logic [6:0] ADDR_P_MID = 7'h29;
    localparam logic [6:0] ADDR_P_HIGH = 7'h2A;
    localparam logic [6:0] ADDR_T_LOW = 7'h2B;
    localparam logic [6:0] ADDR_T_HIGH = 7'h2C;
    // control_two fields
    localparam int BIT_FIFO_EN = 6;
    localparam int BIT_STOP_WM = 5;
    localparam int BIT_ADDR_INC = 4;
    // interrupt_routing_control fields
    localparam int BIT_DRDY_IE = 2;
    localparam int BIT_OVR_IE = 3;
    localparam int BIT_WM_IE = 4;
    localparam int BIT_FULL_IE = 5;
    // buffer_control fields
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int WM_HI = 4;
    localparam int WM_LO = 0;
    // buffer_state fields
    localparam int BIT_WM_FLAG = 7;
    localparam int BIT_OVR_FLAG = 6;
    // reset values
    localparam logic [7:0] RST_INT_CFG = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h10;
    localparam logic [7:0] RST_IRQ_ROUTE = 8'h00;
    localparam logic [7:0] RST_BUF_CTRL = 8'h00;
    // buffer_mode_code values
    localparam logic [2:0] MODE_BYPASS = 3'h0;
    localparam logic [2:0] MODE_FIFO = 3'h1;
    localparam logic [2:0] MODE_STREAM = 3'h2;
    localparam logic [2:0] MODE_STR2FIFO = 3'h3;
    localparam logic [2:0] MODE_BYP2STR = 3'h4;
    localparam logic [2:0] MODE_DYN = 3'h6;
    localparam logic [2:0] MODE_BYP2FIFO = 3'h7;
    // sizes
    localparam int DEPTH = 32;
    localparam int SAMPLE_W = 40;
    localparam int TRIM_WORDS = 8;

    typedef enum {BH_BYPASS, BH_FIFO, BH_STREAM, BH_DYN} behav_t;
    typedef enum {LD_LOAD, LD_RUN} load_t;
endpackage : sample_fifo_pkg

// ==== rtl/sensor_sample_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - buffer holds 32 entries of 40 bits, pressure and temperature together
// - buffer works only with enable set; mode field selects operating mode
// - watermark flag set while unread count is at least the watermark
// - watermark zero forces the watermark flag low
// - overrun flag reads one once a stored entry was overwritten unread
// - six-bit level reports unread entries, zero empty, 32 full
// - bypass keeps buffer empty; newest sample overwrites the single slot
// - writing bypass clears contents; host restarts with FIFO code
// - FIFO mode stores samples and stops accepting once full
// - stop-at-watermark limits depth to watermark plus one
// - stream mode accepts every sample, dropping the oldest when full
// - stream keeps last read entry; next sample raises level 0 to 2
// - overrun overwrites oldest entry and may drive the interrupt pin
// - dynamic stream returns first post-empty sample first, counts only new
// - watermark, overrun and level routable to the interrupt pin
// - code 011 is FIFO while interrupt active, stream otherwise
// - code 100 is stream while interrupt active, bypass otherwise
// - code 111 is FIFO while interrupt active, bypass otherwise
// - pressure is 24-bit two's complement, low byte 28h, high 2Ah
// - data-ready pulses for each new pressure and temperature set
// - trimming values are copied from storage before normal operation
// - read of 28h pops oldest entry; burst wraps 2Ch back to 28h
module sensor_sample_fifo #(
    parameter int DEPTH = sample_fifo_pkg::DEPTH,
    parameter int SAMPLE_W = sample_fifo_pkg::SAMPLE_W,
    parameter int TRIM_WORDS = sample_fifo_pkg::TRIM_WORDS
) (
    input wire logic clk, // 200 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic sampleValid, // new sample offered
    input wire logic [SAMPLE_W-1:0] sampleData, // {temp16, press24}
    output logic sampleReady, // sample taken when high with valid
    input wire logic irqActive, // interrupt_active_flag from threshold logic
    input wire logic [6:0] regAddr, // register address
    input wire logic regBurst, // continue at next address of a burst
    input wire logic regWrEn, // write strobe
    input wire logic [7:0] regWrData, // write data
    input wire logic regRdEn, // read strobe
    output logic [7:0] regRdData, // read data, one cycle after strobe
    output logic interruptPin, // interrupt_pin, active high
    output logic dataReady, // one-cycle pulse per new sample
    output logic [$clog2(TRIM_WORDS)-1:0] trimAddr, // trim storage address
    input wire logic [7:0] trimData, // trim storage data, valid in the cycle the address stands
    output logic trimDone, // trim copy complete
    output logic [TRIM_WORDS*8-1:0] trimValues // working trim registers
);
    localparam int AW = $clog2(DEPTH);
    localparam int TW = $clog2(TRIM_WORDS);
    localparam logic [AW:0] FULL_LEVEL = AW'(0) + (AW+1)'(DEPTH);

    function automatic sample_fifo_pkg::behav_t decodeBehav(input logic en, input logic [2:0] m, input logic ia);
        sample_fifo_pkg::behav_t b;
        b = sample_fifo_pkg::BH_BYPASS;
        if (en) begin
            case (m)
                sample_fifo_pkg::MODE_FIFO: b = sample_fifo_pkg::BH_FIFO;
                sample_fifo_pkg::MODE_STREAM: b = sample_fifo_pkg::BH_STREAM;
                sample_fifo_pkg::MODE_DYN: b = sample_fifo_pkg::BH_DYN;
                sample_fifo_pkg::MODE_STR2FIFO: begin
                    b = ia ? sample_fifo_pkg::BH_FIFO : sample_fifo_pkg::BH_STREAM;
                end
                sample_fifo_pkg::MODE_BYP2STR: begin
                    b = ia ? sample_fifo_pkg::BH_STREAM : sample_fifo_pkg::BH_BYPASS;
                end
                sample_fifo_pkg::MODE_BYP2FIFO: begin
                    b = ia ? sample_fifo_pkg::BH_FIFO : sample_fifo_pkg::BH_BYPASS;
                end
                default: b = sample_fifo_pkg::BH_BYPASS;
            endcase
        end
        return b;
    endfunction : decodeBehav

    logic [7:0] intCfg_r, ctrlTwo_r, irqRoute_r, bufCtrl_r;
    logic [SAMPLE_W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r, rdPtr_r, wrPtr_nxt, rdPtr_nxt;
    logic [AW:0] level_r, level_nxt;
    logic keepLast_r, keepLast_nxt, overrun_r, overrun_nxt;
    logic [SAMPLE_W-1:0] outHold_r, popWord;
    logic [6:0] nextAddr_r, effAddr;
    logic [SAMPLE_W-1:0] skid_r [2];
    logic [1:0] skidCnt_r, skidCnt_nxt;
    logic skidHead_r;
    sample_fifo_pkg::load_t load_r;
    logic [TW:0] trimCnt_r;
    logic trimCap_r;
    logic [TW-1:0] trimCapAddr_r;
    sample_fifo_pkg::behav_t behav;
    logic [AW:0] depthLimit;
    logic wmFlag, full, drainReady, push, pop, rdStrobe, wrStrobe, skidIn;

    assign rdStrobe = regRdEn && !regWrEn;
    assign wrStrobe = regWrEn;
    assign effAddr = (regBurst && ctrlTwo_r[sample_fifo_pkg::BIT_ADDR_INC]) ? nextAddr_r : regAddr;
    assign behav = decodeBehav(ctrlTwo_r[sample_fifo_pkg::BIT_FIFO_EN],
                               bufCtrl_r[sample_fifo_pkg::MODE_HI:sample_fifo_pkg::MODE_LO],
                               irqActive);
    assign depthLimit = ctrlTwo_r[sample_fifo_pkg::BIT_STOP_WM]
                      ? {1'b0, bufCtrl_r[sample_fifo_pkg::WM_HI:sample_fifo_pkg::WM_LO]} + (AW+1)'(1)
                      : FULL_LEVEL;
    assign full = level_r >= depthLimit;
    assign wmFlag = (bufCtrl_r[sample_fifo_pkg::WM_HI:sample_fifo_pkg::WM_LO] != 5'h00)
                  && (level_r >= {1'b0, bufCtrl_r[sample_fifo_pkg::WM_HI:sample_fifo_pkg::WM_LO]});
    assign pop = rdStrobe && effAddr == sample_fifo_pkg::ADDR_P_LOW
              && behav != sample_fifo_pkg::BH_BYPASS && level_r != '0;
    // a full FIFO stalls the skid buffer, and through it the sample source
    assign drainReady = load_r == sample_fifo_pkg::LD_RUN
                     && !(behav == sample_fifo_pkg::BH_FIFO && full && !pop);
    assign push = skidCnt_r != 2'h0 && drainReady;
    assign skidIn = sampleValid && sampleReady;
    assign popWord = (behav == sample_fifo_pkg::BH_BYPASS) ? mem[0] : (level_r != '0 ? mem[rdPtr_r] : outHold_r);

    // two-entry skid buffer between the sample source and the buffer
    always_comb begin
        skidCnt_nxt = skidCnt_r + 2'(skidIn) - 2'(push);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            skidCnt_r <= 2'h0;
            skidHead_r <= 1'b0;
            sampleReady <= 1'b0;
        end else begin
            skidCnt_r <= skidCnt_nxt;
            if (push) begin
                skidHead_r <= ~skidHead_r;
            end
            sampleReady <= skidCnt_nxt != 2'h2;
        end
    end

    always_ff @(posedge clk) begin
        if (skidIn) begin
            // with one word held the new one goes behind it, even while the head drains
            skid_r[skidHead_r ^ (skidCnt_r == 2'h1)] <= sampleData;
        end
    end

    // pointer, level and flag updates
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        level_nxt = level_r;
        keepLast_nxt = keepLast_r;
        overrun_nxt = overrun_r;
        if (behav == sample_fifo_pkg::BH_BYPASS) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            level_nxt = '0;
            keepLast_nxt = 1'b0;
            overrun_nxt = 1'b0;
        end else begin
            if (pop) begin
                rdPtr_nxt = rdPtr_r + AW'(1);
                level_nxt = level_r - (AW+1)'(1);
                overrun_nxt = 1'b0;
                // stream keeps the entry just read, dynamic stream does not
                keepLast_nxt = level_r == (AW+1)'(1) && behav == sample_fifo_pkg::BH_STREAM;
            end
            if (push) begin
                wrPtr_nxt = wrPtr_r + AW'(1);
                // dynamic stream counts only new samples, so a kept entry is ignored there
                if (keepLast_nxt && behav == sample_fifo_pkg::BH_STREAM) begin
                    rdPtr_nxt = rdPtr_nxt - AW'(1);
                    level_nxt = (AW+1)'(2);
                    keepLast_nxt = 1'b0;
                end else if (level_nxt >= depthLimit) begin
                    rdPtr_nxt = rdPtr_nxt + AW'(1);
                    overrun_nxt = 1'b1;
                end else begin
                    level_nxt = level_nxt + (AW+1)'(1);
                    keepLast_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            level_r <= '0;
            keepLast_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            level_r <= level_nxt;
            keepLast_r <= keepLast_nxt;
            overrun_r <= overrun_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[behav == sample_fifo_pkg::BH_BYPASS ? AW'(0) : wrPtr_r] <= skid_r[skidHead_r];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dataReady <= 1'b0;
        end else begin
            dataReady <= push;
        end
    end

    // register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intCfg_r <= sample_fifo_pkg::RST_INT_CFG;
            ctrlTwo_r <= sample_fifo_pkg::RST_CTRL_TWO;
            irqRoute_r <= sample_fifo_pkg::RST_IRQ_ROUTE;
            bufCtrl_r <= sample_fifo_pkg::RST_BUF_CTRL;
        end else if (wrStrobe) begin
            case (effAddr)
                sample_fifo_pkg::ADDR_INT_CFG: intCfg_r <= regWrData;
                sample_fifo_pkg::ADDR_CTRL_TWO: ctrlTwo_r <= regWrData;
                sample_fifo_pkg::ADDR_IRQ_ROUTE: irqRoute_r <= regWrData;
                sample_fifo_pkg::ADDR_BUF_CTRL: bufCtrl_r <= regWrData;
                default: ;
            endcase
        end
    end

    // register reads and burst address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 8'h00;
            outHold_r <= '0;
            nextAddr_r <= 7'h00;
        end else begin
            if (rdStrobe || wrStrobe) begin
                nextAddr_r <= (effAddr == sample_fifo_pkg::ADDR_T_HIGH) ? sample_fifo_pkg::ADDR_P_LOW
                            : effAddr + 7'h01;
            end
            if (rdStrobe) begin
                case (effAddr)
                    sample_fifo_pkg::ADDR_INT_CFG: regRdData <= intCfg_r;
                    sample_fifo_pkg::ADDR_CTRL_TWO: regRdData <= ctrlTwo_r;
                    sample_fifo_pkg::ADDR_IRQ_ROUTE: regRdData <= irqRoute_r;
                    sample_fifo_pkg::ADDR_BUF_CTRL: regRdData <= bufCtrl_r;
                    sample_fifo_pkg::ADDR_BUF_STATE: regRdData <= {wmFlag, overrun_r, level_r};
                    sample_fifo_pkg::ADDR_P_LOW: begin
                        outHold_r <= popWord;
                        regRdData <= popWord[7:0];
                    end
                    sample_fifo_pkg::ADDR_P_MID: regRdData <= outHold_r[15:8];
                    sample_fifo_pkg::ADDR_P_HIGH: regRdData <= outHold_r[23:16];
                    sample_fifo_pkg::ADDR_T_LOW: regRdData <= outHold_r[31:24];
                    sample_fifo_pkg::ADDR_T_HIGH: regRdData <= outHold_r[39:32];
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interruptPin <= 1'b0;
        end else begin
            interruptPin <= (irqRoute_r[sample_fifo_pkg::BIT_OVR_IE] && overrun_r)
                         || (irqRoute_r[sample_fifo_pkg::BIT_WM_IE] && wmFlag)
                         || (irqRoute_r[sample_fifo_pkg::BIT_FULL_IE] && level_r == FULL_LEVEL)
                         || (irqRoute_r[sample_fifo_pkg::BIT_DRDY_IE] && dataReady);
        end
    end

    // trim copy after reset; storage answers within the cycle in which the address stands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            load_r <= sample_fifo_pkg::LD_LOAD;
            trimCnt_r <= '0;
            trimAddr <= '0;
            trimCap_r <= 1'b0;
            trimCapAddr_r <= '0;
            trimDone <= 1'b0;
            trimValues <= '0;
        end else begin
            trimCap_r <= 1'b0;
            case (load_r)
                sample_fifo_pkg::LD_LOAD: begin
                    if (trimCnt_r < (TW+1)'(TRIM_WORDS)) begin
                        trimAddr <= trimCnt_r[TW-1:0];
                        trimCapAddr_r <= trimCnt_r[TW-1:0];
                        trimCap_r <= 1'b1;
                        trimCnt_r <= trimCnt_r + (TW+1)'(1);
                    end else if (!trimCap_r) begin
                        load_r <= sample_fifo_pkg::LD_RUN;
                        trimDone <= 1'b1;
                    end
                end
                sample_fifo_pkg::LD_RUN: trimDone <= 1'b1;
                default: load_r <= sample_fifo_pkg::LD_LOAD;
            endcase
            if (trimCap_r) begin
                trimValues[trimCapAddr_r*8 +: 8] <= trimData;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_pushFull;
        push && behav == sample_fifo_pkg::BH_STREAM && !pop && !keepLast_r && level_r >= depthLimit;
    endsequence
    property p_wmZero;
        bufCtrl_r[sample_fifo_pkg::WM_HI:sample_fifo_pkg::WM_LO] == 5'h00 |-> !wmFlag;
    endproperty
    a_wmZero: assert property (p_wmZero) else $error("watermark flag set with zero watermark");
    property p_wmSet;
        level_r >= 6'(bufCtrl_r[4:0]) && bufCtrl_r[4:0] != 5'h00 && rdStrobe && effAddr == sample_fifo_pkg::ADDR_BUF_STATE
            |=> regRdData[sample_fifo_pkg::BIT_WM_FLAG];
    endproperty
    a_wmSet: assert property (p_wmSet) else $error("watermark flag not read back");
    property p_overrun;
        s_pushFull |=> overrun_r && $stable(level_r);
    endproperty
    a_overrun: assert property (p_overrun) else $error("stream overwrite missing overrun");
    property p_bypassEmpty;
        behav == sample_fifo_pkg::BH_BYPASS |=> level_r == '0 && !overrun_r;
    endproperty
    a_bypassEmpty: assert property (p_bypassEmpty) else $error("bypass left entries");
    property p_fifoStall;
        behav == sample_fifo_pkg::BH_FIFO && full && !pop |-> !push;
    endproperty
    a_fifoStall: assert property (p_fifoStall) else $error("full FIFO accepted a sample");
    property p_levelMax;
        level_r <= FULL_LEVEL;
    endproperty
    a_levelMax: assert property (p_levelMax) else $error("level beyond depth");
    property p_keepLast;
        keepLast_r && behav == sample_fifo_pkg::BH_STREAM && push && !pop |=> level_r == 6'h02;
    endproperty
    a_keepLast: assert property (p_keepLast) else $error("stream level did not rise to two");
    property p_drdy;
        push |=> dataReady ##1 (dataReady == $past(push));
    endproperty
    a_drdy: assert property (p_drdy) else $error("data ready not pulsed");
    property p_noRunBeforeTrim;
        load_r == sample_fifo_pkg::LD_LOAD |-> !push;
    endproperty
    a_noRunBeforeTrim: assert property (p_noRunBeforeTrim) else $error("sample taken before trim copy");
    property p_wrap;
        (rdStrobe || wrStrobe) && effAddr == sample_fifo_pkg::ADDR_T_HIGH
            |=> nextAddr_r == sample_fifo_pkg::ADDR_P_LOW;
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst address did not wrap");
    property p_ovrPin;
        irqRoute_r[sample_fifo_pkg::BIT_OVR_IE] && overrun_r |=> interruptPin;
    endproperty
    a_ovrPin: assert property (p_ovrPin) else $error("overrun not routed to interrupt pin");
    property p_popLevel;
        pop && !push |=> level_r == $past(level_r) - (AW+1)'(1);
    endproperty
    a_popLevel: assert property (p_popLevel) else $error("pop did not lower the level");
    property p_dynLevel;
        behav == sample_fifo_pkg::BH_DYN && level_r == '0 && push && !pop |=> level_r == (AW+1)'(1);
    endproperty
    a_dynLevel: assert property (p_dynLevel) else $error("dynamic stream counted an old entry");
    property p_trimHold;
        trimDone |=> trimDone;
    endproperty
    a_trimHold: assert property (p_trimHold) else $error("trim done dropped");
endmodule : sensor_sample_fifo
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int LATCH_BIT = 2
) (
    input wire logic clk, // register clock
    output logic [6:0] regAddr, // register address
    output logic regBurst, // continue a burst
    output logic regWrEn, // write strobe
    output logic [7:0] regWrData, // write data
    output logic regRdEn, // read strobe
    input wire logic [7:0] regRdData // read data
);
    initial begin
        regAddr = 7'h00;
        regBurst = 1'b0;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regBurst <= 1'b0;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask : wr
    // data lands on the edge after the strobe, so look just past it
    task automatic rd(input logic [6:0] a, input logic b, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regBurst <= b;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
    // always passes through bypass so the buffer restarts clean
    task automatic setMode(input logic [2:0] m, input logic [4:0] wm);
        if (m == 3'h3 || m == 3'h4 || m == 3'h7) wr(7'h0B, 8'(1 << LATCH_BIT));
        wr(sample_fifo_pkg::ADDR_BUF_CTRL, 8'h00);
        wr(sample_fifo_pkg::ADDR_BUF_CTRL, {m, wm});
    endtask : setMode
endmodule : host_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, arst_n, sampleValid, sampleReady, irqActive, regBurst, regWrEn, regRdEn;
    logic interruptPin, dataReady, trimDone;
    logic [39:0] sampleData;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, trimData, d;
    logic [2:0] trimAddr;
    logic [63:0] trimValues, expTrim;
    int err_total = 0;
    int n_compared = 0;
    int drCnt = 0;
    int cyc = 0;
    sensor_sample_fifo dut_u (.clk(clk), .arst_n(arst_n), .sampleValid(sampleValid), .sampleData(sampleData),
        .sampleReady(sampleReady), .irqActive(irqActive), .regAddr(regAddr), .regBurst(regBurst),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .interruptPin(interruptPin), .dataReady(dataReady), .trimAddr(trimAddr), .trimData(trimData),
        .trimDone(trimDone), .trimValues(trimValues));
    host_model host_u (.clk(clk), .regAddr(regAddr), .regBurst(regBurst), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
    always #2.5 clk = ~clk;
    // trim storage answers within the cycle in which the address stands
    assign trimData = 8'h30 + {5'h00, trimAddr};
    always @(posedge clk) begin
        if (dataReady === 1'b1) drCnt++;
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    function automatic logic [39:0] smp(input logic [7:0] i);
        return {8'h70, i, 8'h80 | i, ~i, i};
    endfunction : smp
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic stat(input logic [7:0] e);
        host_u.rd(sample_fifo_pkg::ADDR_BUF_STATE, 1'b0, d);
        chk("status", {56'h0, e}, {56'h0, d});
    endtask : stat
    // hold valid until the edge that sees ready, then release
    task automatic push(input int n, input logic [7:0] base);
        int k;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            sampleData <= smp(base + 8'(i));
            sampleValid <= 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (sampleReady !== 1'b1 && k < 50);
            sampleValid <= 1'b0;
            if (k >= 50) chk("sampleReady", 64'h1, 64'h0);
        end
        repeat (4) @(posedge clk);
    endtask : push
    task automatic pops(input int n);
        for (int i = 0; i < n; i++) host_u.rd(sample_fifo_pkg::ADDR_P_LOW, 1'b0, d);
    endtask : pops
    task automatic t_reset;
        logic [7:0] regs [5] = '{8'h0B, 8'h11, 8'h12, 8'h14, 8'h7F};
        logic [7:0] exps [5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) expTrim[8*i+:8] = 8'h30 + 8'(i);
        chk("trimValues", expTrim, trimValues);
        for (int i = 0; i < 5; i++) begin
            host_u.rd(regs[i][6:0], 1'b0, d);
            chk("reset register", {56'h0, exps[i]}, {56'h0, d});
        end
        host_u.setMode(sample_fifo_pkg::MODE_FIFO, 5'h00);
        push(2, 8'h40);
        stat(8'h00);
        chk("interruptPin", 64'h0, {63'h0, interruptPin});
    endtask : t_reset
    task automatic t_fifo;
        logic [39:0] w;
        host_u.wr(sample_fifo_pkg::ADDR_CTRL_TWO, 8'h50);
        host_u.wr(sample_fifo_pkg::ADDR_IRQ_ROUTE, 8'h10);
        host_u.setMode(sample_fifo_pkg::MODE_FIFO, 5'h04);
        drCnt = 0;
        push(32, 8'h00);
        stat(8'hA0);
        chk("dataReady count", 64'h20, 64'(drCnt));
        chk("interruptPin", 64'h1, {63'h0, interruptPin});
        // first entry is popped but not compared; checks start once the burst wraps back to 28h
        for (int k = 0; k < 11; k++) begin
            host_u.rd(sample_fifo_pkg::ADDR_P_LOW, k != 0, d);
            w = smp(8'(k / 5));
            if (k >= 5) chk("burst byte", {56'h0, w[8*(k%5)+:8]}, {56'h0, d});
        end
        stat(8'h9D);
        host_u.wr(sample_fifo_pkg::ADDR_BUF_CTRL, 8'h20);
        stat(8'h1D);
        chk("interruptPin", 64'h0, {63'h0, interruptPin});
        host_u.wr(sample_fifo_pkg::ADDR_BUF_CTRL, 8'h00);
        stat(8'h00);
        push(2, 8'h50);
        stat(8'h00);
        host_u.rd(sample_fifo_pkg::ADDR_P_LOW, 1'b0, d);
        chk("bypass newest", 64'h51, {56'h0, d});
    endtask : t_fifo
    task automatic t_stopwm;
        host_u.wr(sample_fifo_pkg::ADDR_CTRL_TWO, 8'h70);
        host_u.setMode(sample_fifo_pkg::MODE_FIFO, 5'h03);
        push(6, 8'h20);
        stat(8'h84);
        host_u.wr(sample_fifo_pkg::ADDR_CTRL_TWO, 8'h50);
    endtask : t_stopwm
    task automatic t_stream;
        host_u.wr(sample_fifo_pkg::ADDR_IRQ_ROUTE, 8'h08);
        host_u.setMode(sample_fifo_pkg::MODE_STREAM, 5'h00);
        push(34, 8'h00);
        stat(8'h60);
        chk("interruptPin", 64'h1, {63'h0, interruptPin});
        host_u.wr(sample_fifo_pkg::ADDR_IRQ_ROUTE, 8'h20);
        host_u.rd(sample_fifo_pkg::ADDR_P_LOW, 1'b0, d);
        chk("interruptPin full", 64'h1, {63'h0, interruptPin});
        chk("oldest kept", 64'h02, {56'h0, d});
        pops(31);
        stat(8'h00);
        chk("interruptPin", 64'h0, {63'h0, interruptPin});
        push(1, 8'h60);
        stat(8'h02);
    endtask : t_stream
    task automatic t_dyn;
        host_u.setMode(sample_fifo_pkg::MODE_DYN, 5'h00);
        push(3, 8'h10);
        pops(3);
        push(1, 8'h18);
        stat(8'h01);
        host_u.rd(sample_fifo_pkg::ADDR_P_LOW, 1'b0, d);
        chk("dynamic first", 64'h18, {56'h0, d});
    endtask : t_dyn
    task automatic t_trig;
        logic [2:0] modes [3] = '{3'h3, 3'h4, 3'h7};
        for (int m = 0; m < 3; m++) begin
            for (int a = 0; a < 2; a++) begin
                @(posedge clk);
                irqActive <= a[0];
                host_u.setMode(modes[m], 5'h00);
                push(2, 8'h30);
                stat((a == 1 || modes[m] == 3'h3) ? 8'h02 : 8'h00);
            end
        end
    endtask : t_trig
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        sampleValid = 1'b0;
        sampleData = 40'h00_0000_0000;
        irqActive = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 100 && trimDone !== 1'b1; k++) @(posedge clk);
        chk("trimDone", 64'h1, {63'h0, trimDone});
        t_reset();
        t_fifo();
        t_stopwm();
        t_stream();
        t_dyn();
        t_trig();
        results();
    end
endmodule : tb
`default_nettype wire
